// file: logic/scm_card.sv
// Summary of operation
// - Input bit latched on rising clock
// - Compare evaluated on following falling clock
// - Address advances on falling clock, bit shown
// - Attempts write outputs zero, sets code valid
// - Attempts erase outputs code verification result
// - Valid first key sets first erase flag
// - Bit 736 erase clears zone one
// - Unfused zones erase whole word, no flag
// - Counter off: bit 1280 erase clears zone two
// - Bulk zone two shows bit 1280 unchanged
// - Counter write outputs zero, sets second flag
// - Counter erase always outputs zero
// - Counter reset pin clears address
// - Personalize low, reset high: standby
`timescale 1ns/10ps
`default_nettype none
module scm_card
  import scm_pkg::*;
#(
  parameter int PULSE_CYCLES = PROGRAM_PULSE_CYCLES // Least program pulse in clocks
) (
  input wire logic CLK_I, // System clock
  input wire logic RST_I, // Sync reset, power-on
  input wire logic CARD_CLK_I, // Reader clock contact
  input wire logic CTR_RST_I, // Counter reset contact
  input wire logic PROGRAM_CONTROL_I, // Program control contact
  input wire logic PERSONALIZE_PIN_I, // Personalize contact
  input wire logic ISSUER_FUSE_I, // Issuer fuse blown
  input wire logic COUNTER_ENABLE_FUSE_I, // Zone-two erase counter on
  input wire logic DATA_I, // Data line level
  output logic DATA_O, // Data line drive value
  output logic DATA_OE_O, // Data line pull-low enable
  output logic CODE_VALID_FLAG_O, // Security code verified
  output logic FIRST_ZONE_ERASE_FLAG_O, // Zone one erase enabled
  output logic SECOND_ZONE_ERASE_FLAG_O, // Zone two erase enabled
  output logic STANDBY_O, // Standby mode
  output logic PROGRAM_BUSY_O // Program pulse or sweep active
);
  scm_state_t state_reg; // Program sequencer
  logic clk_d_reg; // Previous card clock
  logic [ADDR_W-1:0] addr_reg; // Bit address counter
  logic in_bit_reg; // Latched compare bit
  logic sec_ok_reg, key1_ok_reg, key2_ok_reg; // Running compare results
  logic code_valid_reg, e1_reg, e2_reg; // Sticky flags
  logic ov_en_reg, ov_val_reg; // Output override after program
  logic op_erase_reg; // Pending operation is erase
  logic [PULSE_CNT_W-1:0] cnt_reg; // Program pulse length
  logic [WIDX_W-1:0] sweep_reg, sweep_last_reg; // Bulk erase walk
  logic [WORD_W-1:0] rd_word; // Current word
  logic wr_en; // Array write strobe
  logic [WIDX_W-1:0] wr_idx; // Array write index
  logic [WORD_W-1:0] wr_word; // Array write data
  logic rise, fall, standby, level2, cur_bit, match, commit;

  // Inclusive range check on a bit address
  function automatic logic in_rng(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Running compare: first bit restarts, later bits accumulate
  function automatic logic acc_ok(input logic ok, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] lo, input logic m);
    return (a == lo) ? m : (ok & m);
  endfunction

  // Pin edges and mode decode
  assign rise = CARD_CLK_I & ~clk_d_reg;
  assign fall = ~CARD_CLK_I & clk_d_reg;
  assign standby = ~PERSONALIZE_PIN_I & CTR_RST_I;
  assign level2 = ISSUER_FUSE_I | ~PERSONALIZE_PIN_I;
  assign cur_bit = rd_word[addr_reg[3:0]];
  assign match = in_bit_reg == cur_bit;
  assign commit = (state_reg == ST_ARMED) && fall;

  scm_bit_mem u_mem (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .rd_idx_i((state_reg == ST_SWEEP) ? sweep_reg : addr_reg[ADDR_W-1:4]),
    .rd_word_o(rd_word),
    .wr_en_i(wr_en),
    .wr_idx_i(wr_idx),
    .wr_word_i(wr_word)
  );

  // Card clock edge tracking
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      clk_d_reg <= 1'b0;
    end else begin
      clk_d_reg <= CARD_CLK_I;
    end
  end

  // Address counter: cleared by reset pin, held while programming
  always_ff @(posedge CLK_I) begin
    if (RST_I || CTR_RST_I) begin
      addr_reg <= '0;
    end else if (fall && state_reg == ST_IDLE) begin
      addr_reg <= addr_reg + 11'h001;
    end
  end

  // Compare bit latch; level sampled at the edge, so later changes are ignored
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      in_bit_reg <= 1'b1;
    end else if (rise && state_reg == ST_IDLE && !PROGRAM_CONTROL_I) begin
      in_bit_reg <= DATA_I;
    end
  end

  // Code and key compare on the falling edge
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sec_ok_reg <= 1'b0;
      key1_ok_reg <= 1'b0;
      key2_ok_reg <= 1'b0;
    end else if (fall && state_reg == ST_IDLE) begin
      if (in_rng(addr_reg, SEC_CODE_FIRST, SEC_CODE_LAST)) begin
        sec_ok_reg <= acc_ok(sec_ok_reg, addr_reg, SEC_CODE_FIRST, match);
      end
      if (in_rng(addr_reg, KEY1_FIRST, KEY1_LAST)) begin
        key1_ok_reg <= acc_ok(key1_ok_reg, addr_reg, KEY1_FIRST, match);
      end
      if (in_rng(addr_reg, KEY2_FIRST, KEY2_LAST)) begin
        key2_ok_reg <= acc_ok(key2_ok_reg, addr_reg, KEY2_FIRST, match);
      end
    end
  end

  // Sticky flags, cleared only at power-on
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      code_valid_reg <= 1'b0;
      e1_reg <= 1'b0;
      e2_reg <= 1'b0;
    end else begin
      if (commit && !op_erase_reg && in_rng(addr_reg, ATT_FIRST, ATT_LAST) && sec_ok_reg) begin
        code_valid_reg <= 1'b1;
      end
      if (fall && state_reg == ST_IDLE && addr_reg == KEY1_LAST && acc_ok(key1_ok_reg, addr_reg, KEY1_FIRST, match)) begin
        e1_reg <= 1'b1;
      end
      if (fall && state_reg == ST_IDLE && addr_reg == KEY2_LAST && !COUNTER_ENABLE_FUSE_I
          && acc_ok(key2_ok_reg, addr_reg, KEY2_FIRST, match)) begin
        e2_reg <= 1'b1;
      end
      if (commit && !op_erase_reg && COUNTER_ENABLE_FUSE_I && in_rng(addr_reg, EC2_FIRST, EC2_LAST) && key2_ok_reg) begin
        e2_reg <= 1'b1;
      end
    end
  end

  // Program sequencer: pulse timing, commit, bulk sweep
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      op_erase_reg <= 1'b0;
      sweep_reg <= '0;
      sweep_last_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Program pulse starts on a rising clock with program high
          if (rise && PROGRAM_CONTROL_I && !standby && !CTR_RST_I) begin
            state_reg <= ST_PULSE;
            cnt_reg <= '0;
            op_erase_reg <= DATA_I;
          end
        end
        ST_PULSE: begin
          if (fall || CTR_RST_I) begin
            state_reg <= ST_IDLE; // Too short: nothing programmed
          end else if (cnt_reg == PULSE_CNT_W'(PULSE_CYCLES - 1)) begin
            state_reg <= ST_ARMED;
          end else begin
            cnt_reg <= cnt_reg + 20'h00001;
          end
        end
        ST_ARMED: begin
          if (CTR_RST_I) begin
            state_reg <= ST_IDLE;
          end else if (fall) begin
            // Bulk erases walk the zone words; all else is done now
            if (op_erase_reg && addr_reg == Z1_BULK_BIT && e1_reg) begin
              state_reg <= ST_SWEEP;
              sweep_reg <= Z1_FIRST[ADDR_W-1:4];
              sweep_last_reg <= Z1_LAST[ADDR_W-1:4];
            end else if (op_erase_reg && e2_reg && ((addr_reg == Z2_BULK_BIT && !COUNTER_ENABLE_FUSE_I)
                         || (COUNTER_ENABLE_FUSE_I && in_rng(addr_reg, EC2_FIRST, EC2_LAST)))) begin
              state_reg <= ST_SWEEP;
              sweep_reg <= Z2_FIRST[ADDR_W-1:4];
              sweep_last_reg <= Z2_LAST[ADDR_W-1:4];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_SWEEP: begin
          if (sweep_reg == sweep_last_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            sweep_reg <= sweep_reg + 7'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Array write: sweep, word erase or single-bit write
  always_comb begin
    wr_en = 1'b0;
    wr_idx = addr_reg[ADDR_W-1:4];
    wr_word = ERASED_WORD;
    if (state_reg == ST_SWEEP) begin
      wr_en = 1'b1;
      wr_idx = sweep_reg;
    end else if (commit && !op_erase_reg) begin
      wr_en = in_rng(addr_reg, ATT_FIRST, ATT_LAST) || code_valid_reg
              || (COUNTER_ENABLE_FUSE_I && in_rng(addr_reg, EC2_FIRST, EC2_LAST));
      wr_word = rd_word & ~(16'h0001 << addr_reg[3:0]);
    end else if (commit) begin
      if (in_rng(addr_reg, ATT_FIRST, ATT_LAST)) begin
        wr_en = code_valid_reg;
      end else if (in_rng(addr_reg, Z1_FIRST, Z1_LAST) || in_rng(addr_reg, Z2_FIRST, Z2_LAST)) begin
        wr_en = !level2 && !(addr_reg == Z1_BULK_BIT && e1_reg);
      end else if (!(COUNTER_ENABLE_FUSE_I && in_rng(addr_reg, EC2_FIRST, EC2_LAST))
                   && addr_reg != Z2_BULK_BIT) begin
        wr_en = code_valid_reg;
      end
    end
  end

  // Output override after counter program, dropped at next advance
  always_ff @(posedge CLK_I) begin
    if (RST_I || CTR_RST_I) begin
      ov_en_reg <= 1'b0;
      ov_val_reg <= 1'b1;
    end else if (commit && in_rng(addr_reg, ATT_FIRST, ATT_LAST)) begin
      ov_en_reg <= 1'b1;
      ov_val_reg <= op_erase_reg & code_valid_reg;
    end else if (commit && COUNTER_ENABLE_FUSE_I && in_rng(addr_reg, EC2_FIRST, EC2_LAST)) begin
      ov_en_reg <= 1'b1;
      ov_val_reg <= 1'b0;
    end else if (fall && state_reg == ST_IDLE) begin
      ov_en_reg <= 1'b0;
    end
  end

  // Open-drain data: pull low for a zero; code areas left to the reader
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      DATA_O <= 1'b0;
      DATA_OE_O <= 1'b0;
    end else begin
      DATA_O <= 1'b0;
      DATA_OE_O <= !standby && state_reg == ST_IDLE && !PROGRAM_CONTROL_I && !CTR_RST_I
                   && !in_rng(addr_reg, SEC_CODE_FIRST, SEC_CODE_LAST)
                   && !in_rng(addr_reg, KEY1_FIRST, KEY2_LAST)
                   && !(ov_en_reg ? ov_val_reg : cur_bit);
    end
  end

  // Status outputs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CODE_VALID_FLAG_O <= 1'b0;
      FIRST_ZONE_ERASE_FLAG_O <= 1'b0;
      SECOND_ZONE_ERASE_FLAG_O <= 1'b0;
      STANDBY_O <= 1'b0;
      PROGRAM_BUSY_O <= 1'b0;
    end else begin
      CODE_VALID_FLAG_O <= code_valid_reg;
      FIRST_ZONE_ERASE_FLAG_O <= e1_reg;
      SECOND_ZONE_ERASE_FLAG_O <= e2_reg;
      STANDBY_O <= standby;
      PROGRAM_BUSY_O <= state_reg != ST_IDLE;
    end
  end
endmodule // scm_card
`default_nettype wire

// file: logic/scm_pkg.sv
`default_nettype none
package scm_pkg;
  // Array shape
  localparam int ADDR_W = 11;
  localparam int WORD_W = 16;
  localparam int WORD_CNT = 98;
  localparam int WIDX_W = 7;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
  // Code and counter areas
  localparam logic [ADDR_W-1:0] SEC_CODE_FIRST = 11'h050;
  localparam logic [ADDR_W-1:0] SEC_CODE_LAST = 11'h05f;
  localparam logic [ADDR_W-1:0] ATT_FIRST = 11'h060;
  localparam logic [ADDR_W-1:0] ATT_LAST = 11'h063;
  localparam logic [ADDR_W-1:0] KEY1_FIRST = 11'h510;
  localparam logic [ADDR_W-1:0] KEY1_LAST = 11'h51f;
  localparam logic [ADDR_W-1:0] KEY2_FIRST = 11'h520;
  localparam logic [ADDR_W-1:0] KEY2_LAST = 11'h52f;
  localparam logic [ADDR_W-1:0] EC2_FIRST = 11'h500;
  localparam logic [ADDR_W-1:0] EC2_LAST = 11'h503;
  // Application zones and bulk-erase trigger bits
  localparam logic [ADDR_W-1:0] Z1_FIRST = 11'h0b0;
  localparam logic [ADDR_W-1:0] Z1_LAST = 11'h2af;
  localparam logic [ADDR_W-1:0] Z2_FIRST = 11'h2e0;
  localparam logic [ADDR_W-1:0] Z2_LAST = 11'h4df;
  localparam logic [ADDR_W-1:0] Z1_BULK_BIT = 11'h2e0;
  localparam logic [ADDR_W-1:0] Z2_BULK_BIT = 11'h500;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROGRAM_PULSE_TIME_NS = 3000000;
  localparam int PROGRAM_PULSE_CYCLES = (PROGRAM_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 20;
  // Program sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_ARMED, ST_SWEEP} scm_state_t;
endpackage
`default_nettype wire

// file: logic/scm_bit_mem.sv
`timescale 1ns/10ps
`default_nettype none
module scm_bit_mem
  import scm_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, fills array erased
  input wire logic [WIDX_W-1:0] rd_idx_i, // Read word index
  output logic [WORD_W-1:0] rd_word_o, // Registered read word
  input wire logic wr_en_i, // Write strobe
  input wire logic [WIDX_W-1:0] wr_idx_i, // Write word index
  input wire logic [WORD_W-1:0] wr_word_i // Write word
);
  logic [WORD_W-1:0] mem_reg [WORD_CNT]; // Word array

  // Array update, erased after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORD_CNT; i++) begin
        mem_reg[i] <= ERASED_WORD;
      end
    end else if (wr_en_i) begin
      mem_reg[wr_idx_i] <= wr_word_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_word_o <= ERASED_WORD;
    end else begin
      rd_word_o <= mem_reg[rd_idx_i];
    end
  end
endmodule // scm_bit_mem
`default_nettype wire

// file: dv/scm_card_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module scm_card_monitor (
  input wire logic CLK_I, // Clock
  input wire logic RST_I, // Reset
  input wire logic CARD_CLK_I, // Reader clock
  input wire logic CTR_RST_I, // Counter reset
  input wire logic PROGRAM_CONTROL_I, // Program pin
  input wire logic PERSONALIZE_PIN_I, // Personalize
  input wire logic DATA_OE_O, // Line pull-low
  input wire logic CODE_VALID_FLAG_O, // Code valid
  input wire logic FIRST_ZONE_ERASE_FLAG_O, // Zone one flag
  input wire logic SECOND_ZONE_ERASE_FLAG_O, // Zone two flag
  input wire logic STANDBY_O, // Standby
  input wire logic PROGRAM_BUSY_O // Busy
);
  // One domain, reset disables all
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Flags drop only through reset
  a_cv_sticky: assert property (!$fell(CODE_VALID_FLAG_O)) else $error("code flag dropped");
  a_e1_sticky: assert property (!$fell(FIRST_ZONE_ERASE_FLAG_O)) else $error("e1 dropped");
  a_e2_sticky: assert property (!$fell(SECOND_ZONE_ERASE_FLAG_O)) else $error("e2 dropped");
  // Flags set only after a clock fall
  a_cv_on_fall: assert property ($rose(CODE_VALID_FLAG_O) |-> !CARD_CLK_I && !PROGRAM_CONTROL_I)
    else $error("code flag off fall");
  a_e1_on_fall: assert property ($rose(FIRST_ZONE_ERASE_FLAG_O) |-> !CARD_CLK_I)
    else $error("e1 off fall");
  a_e2_on_fall: assert property ($rose(SECOND_ZONE_ERASE_FLAG_O) |-> !CARD_CLK_I)
    else $error("e2 off fall");
  // Standby follows pin pair
  a_standby_entry: assert property ((!PERSONALIZE_PIN_I && CTR_RST_I) [*2] |=> STANDBY_O)
    else $error("no standby");
  // Line moves only with clock low or in a program
  a_line_on_fall: assert property ($changed(DATA_OE_O) |-> !CARD_CLK_I || PROGRAM_BUSY_O)
    else $error("line moved on high clock");
  // Counter reset ends a program pulse; a bulk erase sweep ignores it and runs to its last word
  a_reset_abort: assert property (CTR_RST_I [*3] |-> !PROGRAM_BUSY_O) else $error("busy in reset");
endmodule // scm_card_monitor
bind scm_card scm_card_monitor mon (.CLK_I(CLK_I), .RST_I(RST_I), .CARD_CLK_I(CARD_CLK_I), .CTR_RST_I(CTR_RST_I),
  .PROGRAM_CONTROL_I(PROGRAM_CONTROL_I), .PERSONALIZE_PIN_I(PERSONALIZE_PIN_I), .DATA_OE_O(DATA_OE_O),
  .CODE_VALID_FLAG_O(CODE_VALID_FLAG_O), .FIRST_ZONE_ERASE_FLAG_O(FIRST_ZONE_ERASE_FLAG_O),
  .SECOND_ZONE_ERASE_FLAG_O(SECOND_ZONE_ERASE_FLAG_O), .STANDBY_O(STANDBY_O), .PROGRAM_BUSY_O(PROGRAM_BUSY_O));
`default_nettype wire

// file: dv/scm_reader.sv
`timescale 1ns/10ps
`default_nettype none
module scm_reader #(
  parameter int PULSE = 8 // Program pulse in clocks
) (
  input wire logic clk_i, // System clock
  output logic card_clk_o, // Card clock
  output logic ctr_rst_o, // Counter reset
  output logic pgm_o, // Program control
  output logic oe_o, // Pull line low when val low
  output logic val_o // Drive value
);
  localparam int HALF = 2; // Clock phase in clocks, short to keep long walks brief
  // All idle low
  initial begin
    card_clk_o = 0;
    ctr_rst_o = 0;
    pgm_o = 0;
    oe_o = 0;
    val_o = 0;
  end
  // Wait n clocks, move just after edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Counter reset level, clock held low
  task automatic set_rst(input logic v);
    ctr_rst_o = v;
    wt(HALF);
  endtask
  // One read or compare bit, pgm low
  task automatic tick(input logic drv, input logic v);
    oe_o = drv;
    val_o = v;
    wt(1);
    card_clk_o = 1;
    wt(HALF);
    card_clk_o = 0;
    wt(1);
    oe_o = 0;
    wt(HALF);
  endtask
  // Erase (1) or write (0) pulse
  task automatic prog(input logic v);
    pgm_o = 1;
    wt(2);
    oe_o = 1;
    val_o = v;
    wt(2);
    card_clk_o = 1;
    wt(PULSE + 2);
    pgm_o = 0;
    wt(2);
    card_clk_o = 0;
    wt(1);
    oe_o = 0;
    wt(40);
  endtask
endmodule // scm_reader
`default_nettype wire

// file: dv/scm_card_tb.sv
`timescale 1ns/10ps
`default_nettype none
module scm_card_tb;
  import scm_pkg::*;
  localparam int PULSE = 8; // Short program pulse
  logic clk, rst, personalize_pin, pers, ecen; // Bench-driven pins
  logic cclk, crst, program_control, r_oe, r_val; // Reader pins
  logic d_o, d_oe, cv, e1, e2, stby, busy; // Card outputs
  logic io; // Resolved line
  int miscompares = 0;
  int total_checks = 0;
  // Open drain with pull-up
  assign io = !d_oe && !(r_oe && !r_val);
  // Clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  scm_card #(.PULSE_CYCLES(PULSE)) dut (.CLK_I(clk), .RST_I(rst), .CARD_CLK_I(cclk), .CTR_RST_I(crst),
    .PROGRAM_CONTROL_I(program_control), .PERSONALIZE_PIN_I(pers), .ISSUER_FUSE_I(personalize_pin), .COUNTER_ENABLE_FUSE_I(ecen),
    .DATA_I(io), .DATA_O(d_o), .DATA_OE_O(d_oe), .CODE_VALID_FLAG_O(cv), .FIRST_ZONE_ERASE_FLAG_O(e1),
    .SECOND_ZONE_ERASE_FLAG_O(e2), .STANDBY_O(stby), .PROGRAM_BUSY_O(busy));
  scm_reader #(.PULSE(PULSE)) rdr (.clk_i(clk), .card_clk_o(cclk), .ctr_rst_o(crst), .pgm_o(program_control),
    .oe_o(r_oe), .val_o(r_val));
  // Compare and count
  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %b got %b", what, exp, got);
    end
  endtask
  // Verdict and end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Short mid-run reset
  task automatic reset_dut();
    rst = 1;
    rdr.wt(3);
    rst = 0;
  endtask
  // Clear counter, then step to address n
  task automatic goto(input int n);
    rdr.set_rst(1);
    rdr.set_rst(0);
    repeat (n) rdr.tick(0, 0);
  endtask
  // Sixteen compare bits, one wrong at bad
  task automatic cmp16(input int bad);
    for (int i = 0; i < 16; i++) rdr.tick(1, i != bad);
  endtask
  // Standby pin pair
  task automatic t_pins();
    pers = 0;
    rdr.set_rst(1);
    chk("standby", 1, stby);
    pers = 1;
    rdr.set_rst(0);
    chk("standby off", 0, stby);
    chk("drive value", 0, d_o);
    $display("pins done");
  endtask
  // Wrong code: no flag, erase shows 0
  task automatic t_bad_code();
    reset_dut();
    goto(80);
    cmp16(5);
    rdr.prog(0);
    chk("write line", 0, io);
    chk("cv wrong", 0, cv);
    rdr.prog(1);
    chk("erase line", 0, io);
    chk("busy after", 0, busy);
    $display("bad code done");
  endtask
  // Right code, then a zone bit write
  task automatic t_good_code();
    reset_dut();
    goto(80);
    cmp16(-1);
    chk("cv early", 0, cv);
    rdr.prog(0);
    chk("write line", 0, io);
    chk("cv set", 1, cv);
    rdr.prog(1);
    chk("erase line", 1, io);
    repeat (80) rdr.tick(0, 0);
    rdr.prog(0);
    chk("bit 176", 0, io);
    rdr.tick(0, 0);
    chk("bit 177", 1, io);
    $display("good code done");
  endtask
  // Bulk erase refused, then allowed by key
  task automatic t_zone1();
    repeat (736 - 177) rdr.tick(0, 0);
    rdr.prog(0);
    chk("bit 736 written", 0, io);
    rdr.prog(1);
    chk("bulk refused", 0, io);
    goto(176);
    chk("kept 176", 0, io);
    repeat (1296 - 176) rdr.tick(0, 0);
    cmp16(-1);
    chk("e1", 1, e1);
    goto(736);
    rdr.prog(1);
    chk("bit 736", 0, io);
    goto(176);
    chk("erased 176", 1, io);
    $display("zone one done");
  endtask
  // Counter off: key sets flag, bit 1280 erase clears zone two
  task automatic t_zone2_off();
    repeat (737 - 176) rdr.tick(0, 0);
    rdr.prog(0);
    chk("bit 737 written", 0, io);
    repeat (1280 - 737) rdr.tick(0, 0);
    rdr.prog(0);
    chk("bit 1280 written", 0, io);
    repeat (32) rdr.tick(0, 0);
    cmp16(-1);
    chk("e2 key", 1, e2);
    goto(1280);
    rdr.prog(1);
    chk("bit 1280 kept", 0, io);
    goto(737);
    chk("erased 737", 1, io);
    $display("zone two bulk done");
  endtask
  // Counter on: flag by write, erase shows 0
  task automatic t_zone2();
    reset_dut();
    ecen = 1;
    goto(1312);
    cmp16(-1);
    chk("e2 early", 0, e2);
    goto(1280);
    rdr.prog(0);
    chk("cnt write", 0, io);
    chk("e2 set", 1, e2);
    rdr.prog(1);
    chk("cnt erase", 0, io);
    $display("zone two done");
  endtask
  // Main sequence
  initial begin
    rst = 1;
    pers = 1;
    personalize_pin = 0;
    ecen = 0;
    repeat (12) @(posedge clk);
    #1 rst = 0;
    t_pins();
    personalize_pin = 1;
    t_bad_code();
    t_good_code();
    t_zone1();
    t_zone2_off();
    t_zone2();
    summarize();
  end
  // Hang guard
  initial begin
    repeat (75000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule // scm_card_tb
`default_nettype wire
